// ==== hbdfc_pkg.sv ====
// Constants for the dual H-bridge decay and fault controller.
// Assumes a single 25 MHz clock; all times are converted to cycle counts here.
package hbdfc_pkg;

  localparam int unsigned CLK_MHZ = 25;

  // Times in nanoseconds, figures as characterised
  localparam int unsigned BLANK_TIME_NS   = 1800;
  localparam int unsigned OFF_TIME_NS     = 20000;
  localparam int unsigned OCP_DEG_NS      = 2800;
  localparam int unsigned RETRY_TIME_NS   = 1600000;
  localparam int unsigned SLEEP_ENTRY_NS  = 1000000;
  localparam int unsigned WAKE_DELAY_NS   = 1000000;

  // Least times round up
  localparam int unsigned BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OFF_CYC   = (OFF_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAST_CYC  = OFF_CYC / 4;
  localparam int unsigned OCP_DEG_CYC = (OCP_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_CYC = (RETRY_TIME_NS / 1000) * CLK_MHZ;
  localparam int unsigned SLEEP_CYC = (SLEEP_ENTRY_NS / 1000) * CLK_MHZ;
  localparam int unsigned WAKE_CYC  = (WAKE_DELAY_NS / 1000) * CLK_MHZ;

  localparam int unsigned CNT_W     = 16;
  localparam int unsigned LONG_W    = 24;

  // Chopper phases, one-hot
  typedef enum logic [3:0] {
    CH_DRIVE = 4'h1,
    CH_FAST  = 4'h2,
    CH_SLOW  = 4'h4,
    CH_OFF   = 4'h8
  } hbdfc_chop_t;

  // Power mode, one-hot
  typedef enum logic [2:0] {
    PM_RUN   = 3'h1,
    PM_ENTER = 3'h2,
    PM_SLEEP = 3'h4
  } hbdfc_pm_t;

endpackage

// ==== hbdfc_bridge.sv ====
// One H-bridge: input decode, fixed off-time chopping with mixed decay,
// and overcurrent deglitch with retry.
// Assumes all inputs are already synchronised to i_mclk.
`timescale 1ns/1ns
`default_nettype none
module hbdfc_bridge #(
  parameter int unsigned RETRY_CYC = hbdfc_pkg::RETRY_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_enable,
  input  wire logic       i_in_a,
  input  wire logic       i_in_b,
  input  wire logic       i_chop_trip,
  input  wire logic       i_zero_cross,
  input  wire logic [3:0] i_ilimit,
  output logic      [3:0] o_gate,
  output logic            o_ocp_fault
);

  // Gate order: [3] high A, [2] low A, [1] high B, [0] low B
  hbdfc_pkg::hbdfc_chop_t st_q;
  hbdfc_pkg::hbdfc_chop_t st_d;
  logic [hbdfc_pkg::CNT_W-1:0]  cnt_q;
  logic [hbdfc_pkg::LONG_W-1:0] ocp_cnt_q;
  logic                         ocp_q;
  logic                         zero_q;
  logic                         fwd_q;

  wire drive_cmd   = i_in_a ^ i_in_b;
  wire fwd_now     = i_in_a & ~i_in_b;
  wire any_limit   = |i_ilimit;
  wire blank_done  = cnt_q >= hbdfc_pkg::CNT_W'(hbdfc_pkg::BLANK_CYC);
  wire fast_done   = cnt_q >= hbdfc_pkg::CNT_W'(hbdfc_pkg::FAST_CYC - 1);
  wire off_done    = cnt_q >= hbdfc_pkg::CNT_W'(hbdfc_pkg::OFF_CYC - 1);
  wire deg_done    = ocp_cnt_q >= hbdfc_pkg::LONG_W'(hbdfc_pkg::OCP_DEG_CYC);
  wire retry_done  = ocp_cnt_q >= hbdfc_pkg::LONG_W'(RETRY_CYC - 1);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      hbdfc_pkg::CH_DRIVE: if (drive_cmd && blank_done && i_chop_trip) st_d = hbdfc_pkg::CH_FAST;
      hbdfc_pkg::CH_FAST:  if (fast_done) st_d = hbdfc_pkg::CH_SLOW;
      hbdfc_pkg::CH_SLOW:  if (off_done) st_d = hbdfc_pkg::CH_DRIVE;
      hbdfc_pkg::CH_OFF:   st_d = hbdfc_pkg::CH_DRIVE;
      default:             st_d = hbdfc_pkg::CH_DRIVE;
    endcase
    if (!drive_cmd || !i_enable || ocp_q)
      st_d = hbdfc_pkg::CH_OFF;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      st_q   <= hbdfc_pkg::CH_OFF;
      cnt_q  <= '0;
      zero_q <= 1'b0;
      fwd_q  <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      // Off time runs from the trip, across both decay phases
      if (st_d != st_q && !(st_q == hbdfc_pkg::CH_FAST && st_d == hbdfc_pkg::CH_SLOW))
        cnt_q <= '0;
      else if (cnt_q != {hbdfc_pkg::CNT_W{1'b1}})
        cnt_q <= cnt_q + 1'b1;
      if (st_q == hbdfc_pkg::CH_DRIVE)
        fwd_q <= fwd_now;
      zero_q <= (st_d == hbdfc_pkg::CH_FAST) & (zero_q | i_zero_cross);
    end
  end

  // Overcurrent: deglitch counts while limit held, then retry wait
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      ocp_q     <= 1'b0;
      ocp_cnt_q <= '0;
    end
    else if (ocp_q)
    begin
      ocp_cnt_q <= ocp_cnt_q + 1'b1;
      if (retry_done)
      begin
        ocp_q     <= 1'b0;
        ocp_cnt_q <= '0;
      end
    end
    else if (any_limit && i_enable)
    begin
      ocp_cnt_q <= ocp_cnt_q + 1'b1;
      if (deg_done)
      begin
        ocp_q     <= 1'b1;
        ocp_cnt_q <= '0;
      end
    end
    else
      ocp_cnt_q <= '0;
  end

  wire [3:0] g_fwd   = 4'h9;
  wire [3:0] g_rev   = 4'h6;
  wire [3:0] g_brake = 4'h5;
  wire [3:0] g_drive = fwd_now ? g_fwd : g_rev;
  wire [3:0] g_decay = fwd_q ? g_rev : g_fwd;
  wire brake_cmd     = i_in_a & i_in_b;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_gate <= 4'h0;
    else if (!i_enable || ocp_q)
      o_gate <= 4'h0;
    else if (brake_cmd)
      o_gate <= g_brake;
    else if (!drive_cmd)
      o_gate <= 4'h0;
    else
    begin
      case (st_d)
        hbdfc_pkg::CH_DRIVE: o_gate <= g_drive;
        hbdfc_pkg::CH_FAST:  o_gate <= (zero_q | i_zero_cross) ? 4'h0 : g_decay;
        hbdfc_pkg::CH_SLOW:  o_gate <= g_brake;
        default:             o_gate <= 4'h0;
      endcase
    end
  end

  assign o_ocp_fault = ocp_q;

endmodule
`default_nettype wire

// ==== hbdfc_top.sv ====
// Top of the dual H-bridge decay and fault controller: pin synchronisers,
// undervoltage and thermal handling, sleep sequencing and fault pin.
// Assumes pin-level inputs are asynchronous to i_mclk; gate outputs feed drivers.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Drive until chopping threshold, then recirculate
// - Decay starts fast, then goes slow
// - Decay period: quarter fast, three quarters slow
// - Fast decay turns on opposite driver pair
// - Near-zero current in fast decay disables bridge
// - Slow decay enables both low-side switches
// - Deglitched current limit disables bridge, faults
// - Retry interval ends overcurrent shutdown automatically
// - Overcurrent handled separately per bridge
// - High and low side limits both detected
// - Overcurrent independent of chopping sense path
// - Over-temperature disables switches until it clears
// - Fault released only after operation resumes
// - Undervoltage resets all core logic until recovery
// - Fault held low during undervoltage
// - No fault indication is latched
// - Sleep input high runs, low sleeps
// - Sleep stops regulator, bridges high-impedance
// - Sleep completes after entry delay
// - Wake automatic; outputs wait wake delay
// - Input pair: coast, reverse, forward, brake
// - Fixed off time after chopping trip
// - Sense ignored for blanking after enable
module hbdfc_top #(
  parameter int unsigned RETRY_CYC = hbdfc_pkg::RETRY_CYC,
  parameter int unsigned SLEEP_CYC = hbdfc_pkg::SLEEP_CYC,
  parameter int unsigned WAKE_CYC  = hbdfc_pkg::WAKE_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_bridge_input_a,
  input  wire logic [1:0] i_bridge_input_b,
  input  wire logic       i_sleep_request_n,
  input  wire logic [1:0] i_chop_trip,
  input  wire logic [1:0] i_zero_cross,
  input  wire logic [7:0] i_ilimit,
  input  wire logic       i_over_temp,
  input  wire logic       i_supply_low,
  input  wire logic       i_supply_ok,
  output logic      [7:0] o_gate,
  output logic            o_regulator_en,
  output logic            o_asleep,
  output logic            o_fault_indicator_n_o,
  output logic            o_fault_indicator_n_oe_n
);

  // Two-stage synchronisers for every pin-level input
  localparam int unsigned NSYNC = 19;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  wire  [NSYNC-1:0] raw_in = {i_bridge_input_a, i_bridge_input_b, i_sleep_request_n,
                              i_chop_trip, i_zero_cross, i_ilimit, i_over_temp,
                              i_supply_ok};

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  wire [1:0] s_in_a     = sync_q[18:17];
  wire [1:0] s_in_b     = sync_q[16:15];
  wire       s_sleep_n  = sync_q[14];
  wire [1:0] s_trip     = sync_q[13:12];
  wire [1:0] s_zero     = sync_q[11:10];
  wire [7:0] s_ilimit   = sync_q[9:2];
  wire       s_hot      = sync_q[1];

  // Undervoltage lockout with hysteresis: falling report, rising recovery
  // Supply-low pin has its own two-stage synchroniser below
  logic uv_q;
  wire  s_supply_ok  = sync_q[0];
  logic sl_meta_q;
  logic sl_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      sl_meta_q <= 1'b0;
      sl_q      <= 1'b0;
    end
    else
    begin
      sl_meta_q <= i_supply_low;
      sl_q      <= sl_meta_q;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      uv_q <= 1'b1;
    else if (sl_q)
      uv_q <= 1'b1;
    else if (s_supply_ok)
      uv_q <= 1'b0;
  end

  // Core logic reset is held by undervoltage as well as the pin reset
  wire core_reset = i_reset | uv_q;

  // Sleep sequencing
  hbdfc_pkg::hbdfc_pm_t pm_q;
  logic [hbdfc_pkg::LONG_W-1:0] pm_cnt_q;
  logic                         wake_q;
  logic [hbdfc_pkg::LONG_W-1:0] wake_cnt_q;
  logic                         sleep_d1_q;

  wire sleep_fall = sleep_d1_q & ~s_sleep_n;
  wire entry_done = pm_cnt_q >= hbdfc_pkg::LONG_W'(SLEEP_CYC - 1);
  wire wake_done  = wake_cnt_q >= hbdfc_pkg::LONG_W'(WAKE_CYC - 1);

  always_ff @(posedge i_mclk)
  begin
    if (core_reset)
    begin
      pm_q       <= hbdfc_pkg::PM_RUN;
      pm_cnt_q   <= '0;
      sleep_d1_q <= 1'b1;
    end
    else
    begin
      sleep_d1_q <= s_sleep_n;
      case (pm_q)
        hbdfc_pkg::PM_RUN:
        begin
          pm_cnt_q <= '0;
          if (sleep_fall)
            pm_q <= hbdfc_pkg::PM_ENTER;
        end
        hbdfc_pkg::PM_ENTER:
        begin
          pm_cnt_q <= pm_cnt_q + 1'b1;
          if (s_sleep_n)
            pm_q <= hbdfc_pkg::PM_RUN;
          else if (entry_done)
            pm_q <= hbdfc_pkg::PM_SLEEP;
        end
        hbdfc_pkg::PM_SLEEP:
        begin
          pm_cnt_q <= '0;
          if (s_sleep_n)
            pm_q <= hbdfc_pkg::PM_RUN;
        end
        default:
          pm_q <= hbdfc_pkg::PM_RUN;
      endcase
    end
  end

  // Wake delay holds outputs idle after sleep or power-up
  always_ff @(posedge i_mclk)
  begin
    if (core_reset)
    begin
      wake_q     <= 1'b1;
      wake_cnt_q <= '0;
    end
    else if (pm_q == hbdfc_pkg::PM_SLEEP)
    begin
      wake_q     <= 1'b1;
      wake_cnt_q <= '0;
    end
    else if (wake_q)
    begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
      if (wake_done)
        wake_q <= 1'b0;
    end
  end

  // After a lockout the bridges stay idle through the wake delay, so the
  // fault is held until that delay ends rather than when the supply returns
  logic restart_q;

  always_ff @(posedge i_mclk)
  begin
    if (core_reset)
      restart_q <= 1'b1;
    else if (!wake_q)
      restart_q <= 1'b0;
  end

  wire asleep  = pm_q == hbdfc_pkg::PM_SLEEP;
  wire running = ~asleep & ~wake_q;
  wire bridge_en = running & ~s_hot;

  logic [1:0] ocp_fault;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_br
      hbdfc_bridge #(
        .RETRY_CYC (RETRY_CYC)
      ) u_bridge (
        .i_mclk       (i_mclk),
        .i_reset      (core_reset),
        .i_enable     (bridge_en),
        .i_in_a       (s_in_a[g]),
        .i_in_b       (s_in_b[g]),
        .i_chop_trip  (s_trip[g]),
        .i_zero_cross (s_zero[g]),
        .i_ilimit     (s_ilimit[4*g+3:4*g]),
        .o_gate       (o_gate[4*g+3:4*g]),
        .o_ocp_fault  (ocp_fault[g])
      );
    end
  endgenerate

  // Fault is a live combination: nothing latched, cleared when drive resumes
  logic fault_q;
  wire  fault_now = uv_q | restart_q | s_hot | (|ocp_fault);

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      fault_q <= 1'b1;
    else
      fault_q <= fault_now;
  end

  // Open drain: output always low, enable active low while pulling
  assign o_fault_indicator_n_o    = 1'b0;
  assign o_fault_indicator_n_oe_n = ~fault_q;

  logic reg_en_q;
  logic asleep_q;

  always_ff @(posedge i_mclk)
  begin
    if (core_reset)
    begin
      reg_en_q <= 1'b0;
      asleep_q <= 1'b0;
    end
    else
    begin
      reg_en_q <= ~asleep;
      asleep_q <= asleep;
    end
  end

  assign o_regulator_en = reg_en_q;
  assign o_asleep       = asleep_q;

endmodule
`default_nettype wire

// ==== hbdfc_assertions.sv ====
// Checker for hbdfc_top: decay order, fault shutdown and sleep timing at the ports.
// Assumes the supply stays good whenever sleep is requested.
`timescale 1ns/1ns
`default_nettype none
module hbdfc_assertions #(
  parameter int unsigned RETRY_CYC = 20,
  parameter int unsigned SLEEP_CYC = 20,
  parameter int unsigned WAKE_CYC  = 20
) (
  input wire logic       i_mclk,
  input wire logic       i_reset,
  input wire logic [1:0] i_bridge_input_a,
  input wire logic [1:0] i_bridge_input_b,
  input wire logic       i_sleep_request_n,
  input wire logic [1:0] i_chop_trip,
  input wire logic [1:0] i_zero_cross,
  input wire logic [7:0] i_ilimit,
  input wire logic       i_over_temp,
  input wire logic       i_supply_low,
  input wire logic       i_supply_ok,
  input wire logic [7:0] o_gate,
  input wire logic       o_regulator_en,
  input wire logic       o_asleep,
  input wire logic       o_fault_indicator_n_o,
  input wire logic       o_fault_indicator_n_oe_n
);
  logic [15:0] fast_q;
  logic [15:0] lim_q;
  logic [15:0] slp_q;
  wire logic [3:0] gate_a = o_gate[3:0];

  // Run lengths of fast decay, bridge A current limit and sleep request
  always_ff @(posedge i_mclk)
  begin
    fast_q <= (i_reset || gate_a != 4'h6) ? 16'h0 : fast_q + 16'h1;
    lim_q  <= (i_reset || i_ilimit[3:0] == 4'h0) ? 16'h0 : lim_q + 16'h1;
    slp_q  <= (i_reset || i_sleep_request_n) ? 16'h0 : slp_q + 16'h1;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  sequence s_drive_on;
    (gate_a != 4'h9) ##1 (gate_a == 4'h9);
  endsequence
  sequence s_fast_on;
    (gate_a == 4'h9) ##1 (gate_a == 4'h6);
  endsequence

  AST_BLANK: assert property (s_drive_on |=> (gate_a == 4'h9) [*8])
    else $error("drive ended inside blanking");
  AST_FAST: assert property (s_fast_on |=> (gate_a inside {4'h6, 4'h0}) [*8])
    else $error("fast decay pair wrong");
  AST_FAST_LEN: assert property (fast_q == hbdfc_pkg::FAST_CYC - 1 && gate_a == 4'h6
    |=> gate_a == 4'h5)
    else $error("fast decay length wrong");
  AST_OCP: assert property (lim_q == 16'h0050 |-> gate_a == 4'h0 && !o_fault_indicator_n_oe_n)
    else $error("current limit not shut down");
  AST_HOT: assert property (i_over_temp [*5] |=> o_gate == 8'h00 && !o_fault_indicator_n_oe_n)
    else $error("over temperature not shut down");
  AST_LOW: assert property (i_supply_low [*5] |=> o_gate == 8'h00 && !o_fault_indicator_n_oe_n)
    else $error("low supply not shut down");
  AST_ASLEEP: assert property (o_asleep |-> o_gate == 8'h00 && !o_regulator_en)
    else $error("asleep with drive or regulator");
  AST_SLEEP_MIN: assert property ($fell(i_sleep_request_n) && !o_asleep |=> !o_asleep [*8])
    else $error("sleep entered early");
  AST_SLEEP_MAX: assert property (slp_q == SLEEP_CYC + 8 && !i_supply_low |-> o_asleep)
    else $error("sleep entered late");
  AST_WAKE: assert property ($rose(i_sleep_request_n) && o_asleep |=> o_gate == 8'h00 [*8])
    else $error("drive inside wake delay");
  AST_PIN: assert property (o_fault_indicator_n_o == 1'b0)
    else $error("fault pin drives high");
endmodule
bind hbdfc_top hbdfc_assertions #(
  .RETRY_CYC(RETRY_CYC),
  .SLEEP_CYC(SLEEP_CYC),
  .WAKE_CYC (WAKE_CYC)
) u_hbdfc_assertions (.*);
`default_nettype wire

// ==== hbdfc_host.sv ====
// Host controller model: maps per-bridge input pairs onto the pin buses.
// Assumes its own inputs change just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module hbdfc_host (
  input  wire logic [1:0] i_pair_a,
  input  wire logic [1:0] i_pair_b,
  input  wire logic       i_run,
  output logic      [1:0] o_in_a,
  output logic      [1:0] o_in_b,
  output logic            o_sleep_n
);
  // Pairs are {first input, second input}; bit 0 of each bus is bridge A
  assign o_in_a    = {i_pair_b[1], i_pair_a[1]};
  assign o_in_b    = {i_pair_b[0], i_pair_a[0]};
  assign o_sleep_n = i_run;
endmodule
`default_nettype wire

// ==== hbdfc_top_bench.sv ====
// Self-checking bench for hbdfc_top, input pair and sleep pins driven through the host model, the rest driven directly.
// Assumes retry, sleep and wake counts shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module hbdfc_top_bench;
  localparam int unsigned CYC = 20;
  logic       i_mclk, i_reset, i_sleep_request_n, i_over_temp, i_supply_low, i_supply_ok;
  logic       o_regulator_en, o_asleep, o_fault_indicator_n_o, o_fault_indicator_n_oe_n, run;
  logic [1:0] i_bridge_input_a, i_bridge_input_b, i_chop_trip, i_zero_cross, pair_a, pair_b;
  logic [7:0] i_ilimit, o_gate;
  int         err_count;
  int         num_checks;

  hbdfc_host u_hbdfc_host (
    .i_pair_a (pair_a),
    .i_pair_b (pair_b),
    .i_run    (run),
    .o_in_a   (i_bridge_input_a),
    .o_in_b   (i_bridge_input_b),
    .o_sleep_n(i_sleep_request_n)
  );
  hbdfc_top #(.RETRY_CYC(CYC), .SLEEP_CYC(CYC), .WAKE_CYC(CYC)) u_hbdfc_top (.*);

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits a bounded time for the gates, then lets them settle before moving on
  task automatic gate_is(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    // First look is off the launching edge so a gate change is settled
    @(negedge i_mclk);
    while (o_gate !== exp && n < lim)
    begin
      @(negedge i_mclk);
      n++;
    end
    cmp("gate", exp, o_gate);
    repeat (10) @(negedge i_mclk);
  endtask

  task automatic fault_is(input logic exp);
    cmp("fault_oe_n", {7'h00, exp}, {7'h00, o_fault_indicator_n_oe_n});
  endtask

  task automatic t_drive;
    logic [7:0] want [4];
    want = '{8'h00, 8'h06, 8'h09, 8'h05};
    for (int c = 0; c < 4; c++)
    begin
      @(posedge i_mclk);
      pair_a <= c[1:0];
      gate_is(want[c], 20);
    end
    $display("drive done");
  endtask

  task automatic t_chop(input logic zc, input logic [7:0] fast_gate);
    @(posedge i_mclk);
    pair_a <= 2'h2;
    gate_is(8'h09, 20);
    @(posedge i_mclk);
    i_chop_trip  <= 2'h1;
    i_zero_cross <= {1'b0, zc};
    gate_is(fast_gate, 60);
    @(posedge i_mclk);
    i_chop_trip  <= 2'h0;
    i_zero_cross <= 2'h0;
    gate_is(8'h05, 140);
    gate_is(8'h09, 420);
    $display("chop done");
  endtask

  task automatic t_ocp;
    @(posedge i_mclk);
    pair_b <= 2'h2;
    gate_is(8'h99, 20);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_mclk);
      i_ilimit <= 8'h01 << i;
      gate_is(8'h90, 100);
      fault_is(1'b0);
      @(posedge i_mclk);
      i_ilimit <= 8'h00;
      gate_is(8'h99, 60);
      fault_is(1'b1);
    end
    $display("overcurrent done");
  endtask

  // Over-temperature when hot is set, otherwise a supply dip
  task automatic t_cut(input logic hot);
    @(posedge i_mclk);
    i_over_temp  <= hot;
    i_supply_low <= !hot;
    i_supply_ok  <= hot;
    gate_is(8'h00, 20);
    fault_is(1'b0);
    @(posedge i_mclk);
    i_over_temp  <= 1'b0;
    i_supply_low <= 1'b0;
    i_supply_ok  <= 1'b1;
    if (!hot)
    begin
      // Supply is back but the wake delay still runs: fault must stand
      repeat (8) @(negedge i_mclk);
      fault_is(1'b0);
    end
    gate_is(8'h99, 80);
    fault_is(1'b1);
    $display("cut done");
  endtask

  task automatic t_sleep;
    int n;
    n = 0;
    @(posedge i_mclk);
    run <= 1'b0;
    while (o_asleep !== 1'b1 && n < 60)
    begin
      @(negedge i_mclk);
      n++;
    end
    cmp("asleep", 8'h01, {7'h00, o_asleep});
    cmp("regulator", 8'h00, {7'h00, o_regulator_en});
    gate_is(8'h00, 1);
    @(posedge i_mclk);
    run <= 1'b1;
    gate_is(8'h99, 80);
    cmp("asleep", 8'h00, {7'h00, o_asleep});
    cmp("regulator", 8'h01, {7'h00, o_regulator_en});
    $display("sleep done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // The whole sequence needs a few thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    err_count    = 0;
    num_checks   = 0;
    i_reset      = 1'b1;
    pair_a       = 2'h0;
    pair_b       = 2'h0;
    run          = 1'b1;
    i_chop_trip  = 2'h0;
    i_zero_cross = 2'h0;
    i_ilimit     = 8'h00;
    i_over_temp  = 1'b0;
    i_supply_low = 1'b0;
    i_supply_ok  = 1'b1;
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (60) @(negedge i_mclk);
    t_drive();
    t_chop(1'b0, 8'h06);
    t_chop(1'b1, 8'h00);
    t_ocp();
    t_cut(1'b1);
    t_cut(1'b0);
    t_sleep();
    wrap_up();
  end
endmodule
`default_nettype wire
